/* File: rtl/pmbus_status_fault_registers.sv */
// status and fault register bank of a two-channel power manager
`timescale 1ns/1ns
// How it works
// [RQ1] bad command sets comm bit 7, bad data sets bit 6.
// [RQ2] extra byte before stop sets bit 5 unless it is matching check byte.
// [RQ3] nonvolatile memory fault sets comm bit 4.
// [RQ4] comm bits 3, 2 and 0 always read zero.
// [RQ5] other malformed bus transaction sets comm bit 1.
// [RQ6] sticky bits hold until clear faults or channel on; global bits unpaged. Shared fault line bits here also clear on a control toggle.
// [RQ7] vendor bits 7,6,5,0 pull alert low; bits 4 to 1 never do.
// [RQ8] shared fault line bits set on turn-on while low or shutdown by line.
// [RQ9] servo reached and dac connected live; dac saturated sticky.
// [RQ10] global bit 1 live aux release; bit 0 sticky watchdog with alert.
// [RQ11] pad word read only, raw synchronised pin levels, no deglitch; here a pin level passes only once two synchroniser stages agree.
// [RQ12] pad drive bits read 0 while the device pulls that pin low.
// [RQ13] address select fields: 11 high, 10 floating, 00 low.
// [RQ14] pad bits show control, shared fault and channel good pin levels.
// [RQ15] only the common status byte is answered while busy.
// [RQ16] busy: command byte refused, busy flag set, alert asserted.
// [RQ17] host may poll common status byte until device is available.
// [RQ18] common byte: not alert, available, ones, timebase held low, write protect.
// [RQ19] secondary bit 2 sticky short cycle fault, raises alert.
// [RQ20] secondary bit 0 sticky input-off, no alert; bit 1 aux drive; rest zero.
// [RQ21] first fault captured once, cleared by clear faults or channel on.
// [RQ22] low 8 timer bits snapshot with first fault, cleared with it.
// [RQ23] first fault word: page, bit number, status command code.
// [RQ24] clear faults clears unpaged and current page bits, releases alert.
// [RQ25] reads never change register contents.
module pmbus_status_fault_registers
   import pmbus_status_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   // bus engine side, on the serial link clock
   input wire logic link_clk,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic cmd_ack,
   input wire logic rd_req,
   output logic [15:0] rd_data,
   output logic rd_valid,
   input wire logic ev_bad_cmd,
   input wire logic ev_bad_data,
   input wire logic ev_extra_byte,
   input wire logic extra_byte_pec_ok,
   input wire logic ev_malformed,
   // core side, on ref_clk
   input wire logic [7:0] page,
   input wire logic clear_faults,
   input wire logic [1:0] ch_on_cmd,
   input wire logic busy,
   input wire logic nvm_fault_ev,
   input wire logic [1:0] discharge_ev,
   input wire logic [1:0] line1_shutdown_ev,
   input wire logic [1:0] line0_shutdown_ev,
   input wire logic [1:0] on_attempt_ev,
   input wire logic [1:0] servo_reached,
   input wire logic [1:0] dac_connected,
   input wire logic [1:0] dac_saturated_ev,
   input wire logic aux_faulted_off,
   input wire logic aux_drive_low,
   input wire logic watchdog_ev,
   input wire logic [1:0] short_cycle_ev,
   input wire logic [1:0] vin_off_ev,
   input wire logic first_fault_ev,
   input wire logic [3:0] first_fault_page,
   input wire logic [3:0] first_fault_bit,
   input wire logic [7:0] first_fault_cmd,
   input wire logic [7:0] shared_timer,
   input wire logic pwrgd_drive_low,
   input wire logic [1:0] fault_line_drive_low,
   input wire logic [1:0] good_pin_drive_low,
   // pins
   input wire logic shared_fault_line0,
   input wire logic shared_fault_line1,
   input wire logic channel0_good_pin,
   input wire logic channel1_good_pin,
   input wire logic control_input0,
   input wire logic control_input1,
   input wire logic [1:0] address_select_level,
   input wire logic [1:0] address_select_float,
   input wire logic write_protect_pin,
   input wire logic share_clk_pin,
   output logic alert_o,
   output logic alert_oe,
   output logic busy_flag,
   output logic [15:0] first_fault_log,
   output logic [7:0] first_fault_timestamp
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;

   assign pin_raw = {share_clk_pin, write_protect_pin, address_select_float,
                     address_select_level, control_input1, control_input0,
                     channel1_good_pin, channel0_good_pin, shared_fault_line1,
                     shared_fault_line0};

   // one-cycle glitch filter here: a level counts once two stages agree
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_r <= '1;
         pin_s2_r <= '1;
         pin_s3_r <= '1;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_r <= '1;
      end else begin
         for (int i = 0; i < PIN_W; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) begin
               pin_r[i] <= pin_s3_r[i]; // RQ11
            end
         end
      end
   end

   logic [1:0] fline, gpin, ctrl, asel_lvl, asel_flt;
   logic wp_lvl, share_lvl;
   assign fline = pin_r[1:0];
   assign gpin = pin_r[3:2];
   assign ctrl = pin_r[5:4];
   assign asel_lvl = pin_r[7:6];
   assign asel_flt = pin_r[9:8];
   assign wp_lvl = pin_r[10];
   assign share_lvl = pin_r[11];

   // control toggles restart the shared fault line history
   logic [1:0] ctrl_d_r;
   logic [1:0] ctrl_toggle;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_d_r <= '1;
      end else begin
         ctrl_d_r <= ctrl;
      end
   end
   assign ctrl_toggle = ctrl ^ ctrl_d_r;

   // ****************************************
   // link domain: events, busy check, read handshake
   // ****************************************
   localparam int EV_W = 5;
   logic [EV_W-1:0] ev_link;
   logic [EV_W-1:0] ev_tgl_r;
   logic busy_l1_r, busy_l2_r, busy_l3_r, busy_lk_r;
   logic req_tgl_r;
   logic [7:0] req_code_r;
   logic ack_l1_r, ack_l2_r, ack_l3_r;
   logic ack_tgl_r;
   logic [15:0] resp_r;
   logic cmd_refused;

   assign cmd_refused = cmd_valid && busy_lk_r && (cmd_code != CMD_COMMON_STATUS);
   assign cmd_ack = cmd_valid && !cmd_refused; // RQ15 RQ16
   assign ev_link = {cmd_refused, ev_malformed, ev_extra_byte && !extra_byte_pec_ok,
                     ev_bad_data, ev_bad_cmd}; // RQ2

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_l1_r <= 1'b0;
         busy_l2_r <= 1'b0;
         busy_l3_r <= 1'b0;
         busy_lk_r <= 1'b0;
      end else begin
         busy_l1_r <= busy;
         busy_l2_r <= busy_l1_r;
         busy_l3_r <= busy_l2_r;
         if (busy_l2_r == busy_l3_r) busy_lk_r <= busy_l3_r;
      end
   end

   // events leave as toggles so a slow or stopped link clock loses none
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         ev_tgl_r <= '0;
      end else begin
         ev_tgl_r <= ev_tgl_r ^ ev_link;
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_tgl_r <= 1'b0;
         req_code_r <= '0;
      end else if (rd_req) begin
         req_tgl_r <= ~req_tgl_r;
         req_code_r <= cmd_code;
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_l1_r <= 1'b0;
         ack_l2_r <= 1'b0;
         ack_l3_r <= 1'b0;
      end else begin
         ack_l1_r <= ack_tgl_r;
         ack_l2_r <= ack_l1_r;
         ack_l3_r <= ack_l2_r;
      end
   end

   // answer word is held stable in ref domain until the next request
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= READ_ZERO;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= ack_l2_r ^ ack_l3_r;
         if (ack_l2_r ^ ack_l3_r) begin
            rd_data <= resp_r;
         end
      end
   end

   // ****************************************
   // ref domain receive side of the crossing
   // ****************************************
   logic [EV_W-1:0] ev_s1_r, ev_s2_r, ev_s3_r, ev_ref;
   logic req_s1_r, req_s2_r, req_s3_r;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ev_s1_r <= '0;
         ev_s2_r <= '0;
         ev_s3_r <= '0;
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else begin
         ev_s1_r <= ev_tgl_r;
         ev_s2_r <= ev_s1_r;
         ev_s3_r <= ev_s2_r;
         req_s1_r <= req_tgl_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end
   assign ev_ref = ev_s2_r ^ ev_s3_r;

   // ****************************************
   // clear masks
   // ****************************************
   logic [1:0] clr_ch;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         clr_ch[c] = (clear_faults && (page == PAGE_GLOBAL || page == 8'(c)))
                     || ch_on_cmd[c]; // RQ6 RQ24
      end
   end

   // ****************************************
   // communication fault byte
   // ****************************************
   logic [7:0] cml_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cml_r <= CML_RESET;
      end else begin
         // set wins over a clear in the same cycle
         if (clear_faults) begin
            cml_r <= CML_RESET; // RQ24
         end
         if (ev_ref[0]) cml_r[CML_CMD_BIT] <= 1'b1; // RQ1
         if (ev_ref[1]) cml_r[CML_DATA_BIT] <= 1'b1; // RQ1
         if (ev_ref[2]) cml_r[CML_PEC_BIT] <= 1'b1; // RQ2
         if (nvm_fault_ev) cml_r[CML_MEM_BIT] <= 1'b1; // RQ3
         if (ev_ref[3]) cml_r[CML_BUS_BIT] <= 1'b1; // RQ5
      end
   end

   // ****************************************
   // busy flag
   // ****************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_flag <= 1'b0;
      end else begin
         busy_flag <= (busy_flag && !clear_faults) || ev_ref[4]; // RQ16
      end
   end

   // ****************************************
   // per-channel sticky status
   // ****************************************
   logic [1:0] disch_r, line1_r, line0_r, sat_r, short_r, vin_off_r;
   logic wdog_r;
   logic [1:0] l1_set, l0_set;
   assign l1_set = line1_shutdown_ev | (on_attempt_ev & {2{!fline[1]}}); // RQ8
   assign l0_set = line0_shutdown_ev | (on_attempt_ev & {2{!fline[0]}}); // RQ8

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         disch_r <= '0;
         line1_r <= '0;
         line0_r <= '0;
         sat_r <= '0;
         short_r <= '0;
         vin_off_r <= '0;
      end else begin
         disch_r <= (disch_r & ~clr_ch) | discharge_ev; // RQ6
         line1_r <= (line1_r & ~(clr_ch | ctrl_toggle)) | l1_set; // RQ8
         line0_r <= (line0_r & ~(clr_ch | ctrl_toggle)) | l0_set; // RQ8
         sat_r <= (sat_r & ~clr_ch) | dac_saturated_ev; // RQ9
         short_r <= (short_r & ~clr_ch) | short_cycle_ev; // RQ19
         vin_off_r <= (vin_off_r & ~clr_ch) | vin_off_ev; // RQ20
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdog_r <= 1'b0;
      end else begin
         wdog_r <= (wdog_r && !clear_faults) || watchdog_ev; // RQ10
      end
   end

   // ****************************************
   // first fault capture
   // ****************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         first_fault_log <= FIRST_FAULT_RESET;
         first_fault_timestamp <= TIMESTAMP_RESET;
      end else if (first_fault_ev && first_fault_log == FIRST_FAULT_RESET) begin
         // capture wins over a clear arriving in the same cycle
         first_fault_log <= {first_fault_page, first_fault_bit, first_fault_cmd}; // RQ21 RQ23
         first_fault_timestamp <= shared_timer; // RQ22
      end else if (clear_faults || |ch_on_cmd) begin
         first_fault_log <= FIRST_FAULT_RESET; // RQ21
         first_fault_timestamp <= TIMESTAMP_RESET; // RQ22
      end
   end

   // ****************************************
   // alert line
   // ****************************************
   logic alert_any;
   assign alert_any = |disch_r || |line1_r || |line0_r || wdog_r // RQ7 RQ10
                      || |short_r || busy_flag; // RQ19 RQ16
   // open drain: only ever drives low
   assign alert_o = 1'b0;
   assign alert_oe = alert_any;

   // ****************************************
   // read answer
   // ****************************************
   function automatic logic [1:0] asel_code(input logic lvl, input logic flt);
      asel_code = flt ? ASEL_FLOAT : (lvl ? ASEL_HIGH : ASEL_LOW); // RQ13
   endfunction

   logic sel;
   logic [7:0] vendor_byte, common_byte;
   logic [15:0] pad_word, sec_word;
   assign sel = page[0];
   assign vendor_byte = {disch_r[sel], line1_r[sel], line0_r[sel], servo_reached[sel],
                         dac_connected[sel], sat_r[sel], aux_faulted_off, wdog_r}; // RQ9 RQ10
   assign pad_word = {!pwrgd_drive_low, !alert_any, !fault_line_drive_low[0],
                      !fault_line_drive_low[1], !good_pin_drive_low[1],
                      !good_pin_drive_low[0], // RQ12
                      asel_code(asel_lvl[1], asel_flt[1]), asel_code(asel_lvl[0], asel_flt[0]),
                      ctrl[1], ctrl[0], fline[0], fline[1], gpin[1], gpin[0]}; // RQ14
   assign common_byte = {!alert_any, !busy, COMMON_ONES, !share_lvl, wp_lvl}; // RQ18 RQ17
   assign sec_word = {SEC_RESERVED, short_r[sel], aux_drive_low, vin_off_r[sel]}; // RQ20

   // reads only sample; nothing here clears a flag
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         resp_r <= READ_ZERO;
         ack_tgl_r <= 1'b0;
      end else if (req_s2_r ^ req_s3_r) begin
         ack_tgl_r <= ~ack_tgl_r; // RQ25
         case (req_code_r)
            CMD_COMM_FAULT: resp_r <= {8'h00, cml_r}; // RQ4
            CMD_VENDOR_STATUS: resp_r <= {8'h00, vendor_byte};
            CMD_PAD_STATE: resp_r <= pad_word;
            CMD_COMMON_STATUS: resp_r <= {8'h00, common_byte};
            CMD_FIRST_FAULT: resp_r <= first_fault_log;
            CMD_SECONDARY: resp_r <= sec_word;
            default: resp_r <= READ_ZERO;
         endcase
      end
   end

endmodule

/* File: rtl/pmbus_status_pkg.sv */
// constants shared by the status and fault register bank
package pmbus_status_pkg;
   // command codes that select a register on a read
   localparam logic [7:0] CMD_COMM_FAULT = 8'h7E;
   localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
   localparam logic [7:0] CMD_PAD_STATE = 8'hE5;
   localparam logic [7:0] CMD_COMMON_STATUS = 8'hEF;
   localparam logic [7:0] CMD_FIRST_FAULT = 8'hB6;
   localparam logic [7:0] CMD_SECONDARY = 8'hB7;
   localparam logic [7:0] PAGE_GLOBAL = 8'hFF;
   // communication fault byte positions
   localparam int CML_CMD_BIT = 7;
   localparam int CML_DATA_BIT = 6;
   localparam int CML_PEC_BIT = 5;
   localparam int CML_MEM_BIT = 4;
   localparam int CML_BUS_BIT = 1;
   // common status byte
   localparam logic [3:0] COMMON_ONES = 4'hF;
   // address select encodings
   localparam logic [1:0] ASEL_HIGH = 2'h3;
   localparam logic [1:0] ASEL_FLOAT = 2'h2;
   localparam logic [1:0] ASEL_LOW = 2'h0;
   // reset values
   localparam logic [7:0] CML_RESET = 8'h00;
   localparam logic [15:0] FIRST_FAULT_RESET = 16'h0000;
   localparam logic [7:0] TIMESTAMP_RESET = 8'h00;
   localparam logic [12:0] SEC_RESERVED = 13'h0000;
   localparam logic [15:0] READ_ZERO = 16'h0000;
   // number of pin inputs passed through the synchroniser
   localparam int PIN_W = 12;
endpackage

/* File: verification/pmbus_status_monitor.sv */
// port assertions for the status and fault register bank
`timescale 1ns/1ns
module pmbus_status_monitor
   import pmbus_status_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic link_clk,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_ack,
   input wire logic rd_req,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic clear_faults,
   input wire logic [1:0] ch_on_cmd,
   input wire logic watchdog_ev,
   input wire logic first_fault_ev,
   input wire logic [3:0] first_fault_page,
   input wire logic [3:0] first_fault_bit,
   input wire logic [7:0] first_fault_cmd,
   input wire logic [7:0] shared_timer,
   input wire logic alert_o,
   input wire logic alert_oe,
   input wire logic [15:0] first_fault_log,
   input wire logic [7:0] first_fault_timestamp
);
   // **********
   // read decode
   // **********
   // code of the read in flight; one read at a time, so it holds until the answer
   logic [7:0] code_r;
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         code_r <= 8'h00;
      end else if (rd_req) begin
         code_r <= cmd_code;
      end
   end
   a_comm_zero_bits: assert property (
      @(posedge link_clk) disable iff (!arst_n) rd_valid && code_r == CMD_COMM_FAULT
      |-> rd_data[3:2] == 2'h0 && rd_data[0] == 1'b0 && rd_data[15:8] == 8'h00)
      else $error("comm byte reserved bits set");
   a_common_ones: assert property (
      @(posedge link_clk) disable iff (!arst_n) rd_valid && code_r == CMD_COMMON_STATUS
      |-> rd_data[5:2] == 4'hF && rd_data[15:8] == 8'h00)
      else $error("common byte fixed ones wrong");
   a_secondary_zero: assert property (
      @(posedge link_clk) disable iff (!arst_n) rd_valid && code_r == CMD_SECONDARY
      |-> rd_data[15:3] == 13'h0000)
      else $error("secondary word upper bits set");
   a_common_acked: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      cmd_valid && cmd_code == CMD_COMMON_STATUS |-> cmd_ack)
      else $error("common status command refused");
   a_alert_pulls_low: assert property (
      @(posedge ref_clk) disable iff (!arst_n) alert_oe |-> !alert_o)
      else $error("alert driven high");
   a_watchdog_alert: assert property (
      @(posedge ref_clk) disable iff (!arst_n) watchdog_ev |=> alert_oe)
      else $error("watchdog fault without alert");
   a_first_capture: assert property (
      @(posedge ref_clk) disable iff (!arst_n) first_fault_ev && first_fault_log == 16'h0000
      |=> first_fault_log == {$past(first_fault_page), $past(first_fault_bit),
      $past(first_fault_cmd)} && first_fault_timestamp == $past(shared_timer))
      else $error("first fault not captured");
   a_first_holds: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      first_fault_log != 16'h0000 && !clear_faults && ch_on_cmd == 2'b00
      |=> $stable(first_fault_log) && $stable(first_fault_timestamp))
      else $error("first fault overwritten");
   a_first_cleared: assert property (
      @(posedge ref_clk) disable iff (!arst_n) clear_faults && !first_fault_ev
      |=> first_fault_log == 16'h0000 && first_fault_timestamp == 8'h00)
      else $error("first fault not cleared");
endmodule

/* File: verification/pmbus_host_model.sv */
// host model driving the bus engine side of the register bank
`timescale 1ns/1ns
module pmbus_host_model (
   input wire logic link_clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   input wire logic cmd_ack,
   output logic rd_req,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   output logic ev_bad_cmd,
   output logic ev_bad_data,
   output logic ev_extra_byte,
   output logic extra_byte_pec_ok,
   output logic ev_malformed
);
   // **********
   // transfers
   // **********
   initial begin
      {cmd_valid, rd_req, ev_bad_cmd, ev_bad_data, ev_extra_byte, ev_malformed} = 6'h00;
      cmd_code = 8'hA5;
      extra_byte_pec_ok = 1'b1;
   end
   // one read in flight; a lost answer leaves unknowns for the caller to catch
   task automatic read(input logic [7:0] c, output logic [15:0] d);
      d = 'x;
      @(negedge link_clk);
      cmd_code = c;
      rd_req = 1'b1;
      @(negedge link_clk);
      rd_req = 1'b0;
      cmd_code = ~c;
      for (int n = 0; n < 12; n++) begin
         @(posedge link_clk);
         #1;
         if (rd_valid === 1'b1) begin
            d = rd_data;
            break;
         end
      end
   endtask
   task automatic cmd(input logic [7:0] c, output logic a);
      @(negedge link_clk);
      cmd_code = c;
      cmd_valid = 1'b1;
      #1 a = cmd_ack;
      @(negedge link_clk);
      cmd_valid = 1'b0;
      cmd_code = ~c;
   endtask
   // mask order: bad command, bad data, extra byte, malformed
   task automatic lev(input logic [3:0] m, input logic ok);
      @(negedge link_clk);
      {ev_bad_cmd, ev_bad_data, ev_extra_byte, ev_malformed} = m;
      extra_byte_pec_ok = ok;
      @(negedge link_clk);
      {ev_bad_cmd, ev_bad_data, ev_extra_byte, ev_malformed} = 4'h0;
      extra_byte_pec_ok = ~ok;
   endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench for the status and fault register bank
`timescale 1ns/1ns
module tb
   import pmbus_status_pkg::*;
;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic arst_n, cmd_valid, cmd_ack, rd_req, rd_valid, busy, busy_flag, a;
   logic ev_bad_cmd, ev_bad_data, ev_extra_byte, extra_byte_pec_ok, ev_malformed;
   logic clear_faults, nvm_fault_ev, watchdog_ev, first_fault_ev, alert_o, alert_oe;
   logic aux_faulted_off, aux_drive_low, pwrgd_drive_low, write_protect_pin, share_clk_pin;
   logic shared_fault_line0, shared_fault_line1, channel0_good_pin, channel1_good_pin;
   logic control_input0, control_input1;
   logic [1:0] ch_on_cmd, discharge_ev, line1_shutdown_ev, line0_shutdown_ev, on_attempt_ev;
   logic [1:0] servo_reached, dac_connected, dac_saturated_ev, short_cycle_ev, vin_off_ev;
   logic [1:0] fault_line_drive_low, good_pin_drive_low, address_select_level;
   logic [1:0] address_select_float;
   logic [3:0] first_fault_page, first_fault_bit;
   logic [7:0] cmd_code, page, first_fault_cmd, shared_timer, first_fault_timestamp;
   logic [15:0] rd_data, first_fault_log, d;
   logic [19:0] evs;
   int n_fail = 0;
   int check_count = 0;
   localparam logic [3:0] lm [5] = '{4'h2, 4'h8, 4'h4, 4'h2, 4'h1};
   localparam logic [4:0] pk = 5'h01;
   localparam logic [15:0] ce [5] = '{16'h0000, 16'h0080, 16'h00C0, 16'h00E0, 16'h00E2};
   assign {watchdog_ev, nvm_fault_ev, first_fault_ev, discharge_ev, line1_shutdown_ev,
      line0_shutdown_ev, dac_saturated_ev, short_cycle_ev, vin_off_ev, ch_on_cmd,
      clear_faults, on_attempt_ev} = evs;
   always #4 ref_clk = ~ref_clk;
   always #15 link_clk = ~link_clk;
   pmbus_status_fault_registers u_dut (.*);
   pmbus_host_model u_host (.*);
   // **********
   // tasks
   // **********
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rp(input logic [19:0] m);
      @(negedge ref_clk) evs = m;
      @(negedge ref_clk) evs = 20'h00000;
   endtask
   // settle time covers the link-to-core crossing of earlier events
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      repeat (4) @(negedge ref_clk);
      u_host.read(c, d);
      chk($sformatf("register %h", c), e, d);
      @(negedge ref_clk);
   endtask
   task automatic results();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      results();
   end
   initial begin
      arst_n = 1'b0;
      evs = 20'h00000;
      {busy, aux_faulted_off, aux_drive_low, servo_reached, dac_connected} = 7'h00;
      page = 8'h00;
      {first_fault_page, first_fault_bit, first_fault_cmd, shared_timer} = 24'h000000;
      {pwrgd_drive_low, fault_line_drive_low, good_pin_drive_low} = 5'h16;
      {address_select_level, address_select_float} = 4'h6;
      {shared_fault_line0, shared_fault_line1, channel0_good_pin, channel1_good_pin,
         control_input0, control_input1, write_protect_pin, share_clk_pin} = 8'h56;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      arst_n = 1'b1;
      for (int i = 0; i < 5; i++) begin
         u_host.lev(lm[i], pk[i]);
         rd(CMD_COMM_FAULT, ce[i]);
      end
      rp(20'h40000);
      rd(CMD_COMM_FAULT, 16'h00F2);
      rd(CMD_COMM_FAULT, 16'h00F2);
      rp(20'h00004);
      rd(CMD_COMM_FAULT, 16'h0000);
      rd(8'h00, 16'h0000);
      rp(20'h00200);
      chk("alert", 1'b0, alert_oe);
      servo_reached = 2'b01;
      dac_connected = 2'b01;
      aux_faulted_off = 1'b1;
      rp(20'h8AA00);
      chk("alert", 1'b1, alert_oe);
      rd(CMD_VENDOR_STATUS, 16'h00FF);
      page = 8'h01;
      rd(CMD_VENDOR_STATUS, 16'h0003);
      page = 8'h00;
      rp(20'h00008);
      rd(CMD_VENDOR_STATUS, 16'h001B);
      rp(20'h00004);
      rd(CMD_VENDOR_STATUS, 16'h001A);
      chk("alert", 1'b0, alert_oe);
      rp(20'h00020);
      chk("alert", 1'b0, alert_oe);
      aux_drive_low = 1'b1;
      rp(20'h00080);
      chk("alert", 1'b1, alert_oe);
      rd(CMD_SECONDARY, 16'h0007);
      rp(20'h00004);
      rd(CMD_SECONDARY, 16'h0002);
      rp(20'h00001);
      chk("alert", 1'b1, alert_oe);
      rd(CMD_VENDOR_STATUS, 16'h003A);
      control_input0 = 1'b1;
      rd(CMD_VENDOR_STATUS, 16'h001A);
      control_input0 = 1'b0;
      rd(CMD_COMMON_STATUS, 16'h00FF);
      busy = 1'b1;
      repeat (16) @(negedge ref_clk);
      u_host.cmd(CMD_VENDOR_STATUS, a);
      chk("ack", 1'b0, a);
      u_host.cmd(CMD_COMMON_STATUS, a);
      chk("ack", 1'b1, a);
      rd(CMD_COMMON_STATUS, 16'h003F);
      chk("busy", 1'b1, busy_flag);
      chk("alert", 1'b1, alert_oe);
      busy = 1'b0;
      for (int n = 0; n < 8 && d[6] !== 1'b1; n++) begin
         u_host.read(CMD_COMMON_STATUS, d);
      end
      chk("common", 16'h007F, d);
      rp(20'h00004);
      chk("busy", 1'b0, busy_flag);
      rd(CMD_PAD_STATE, 16'h56E6);
      shared_fault_line1 = 1'b0;
      rd(CMD_PAD_STATE, 16'h56E2);
      {first_fault_page, first_fault_bit, first_fault_cmd, shared_timer} = 24'h12805A;
      rp(20'h20000);
      rd(CMD_FIRST_FAULT, 16'h1280);
      chk("stamp", 8'h5A, first_fault_timestamp);
      {first_fault_page, first_fault_bit, first_fault_cmd, shared_timer} = 24'hF37CA5;
      rp(20'h20000);
      rd(CMD_FIRST_FAULT, 16'h1280);
      rp(20'h00010);
      rd(CMD_FIRST_FAULT, 16'h0000);
      chk("stamp", 8'h00, first_fault_timestamp);
      rp(20'h20000);
      rd(CMD_FIRST_FAULT, 16'hF37C);
      rp(20'h00004);
      rd(CMD_FIRST_FAULT, 16'h0000);
      results();
   end
endmodule
bind pmbus_status_fault_registers pmbus_status_monitor u_mon (.*);
